// file: fss_regs.svh
`ifndef FSS_REGS_SVH
`define FSS_REGS_SVH
//==================================================================

//==================================================================
// register offsets
`define FSS_A_CTL1 5'h00
`define FSS_A_CTL2 5'h04
`define FSS_A_STAT 5'h08
`define FSS_A_BUF 5'h0C
`define FSS_A_IRQ 5'h10
// control_one fields
`define FSS_C1_MST 5
`define FSS_C1_CKP 6
`define FSS_C1_SEL 7
`define FSS_C1_CKE 8
`define FSS_C1_W16 10
`define FSS_C1_ODIS 11
// control_two fields
`define FSS_C2_DLY 1
`define FSS_C2_POL 13
`define FSS_C2_SFD 14
`define FSS_C2_FRM 15
// status, flag and enable fields
`define FSS_ST_RXF 0
`define FSS_ST_TXF 1
`define FSS_ST_OVF 6
`define FSS_IRQ_EVF 0
`define FSS_IRQ_ERF 1
`define FSS_IRQ_XIE 2
`define FSS_IRQ_EIE 3
// reset values and timing
`define FSS_RST_CTL 16'h0000
`define FSS_SCK_HALF 4
`endif

// file: fss_pkg.sv
package fss_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_ARM, ST_SHIFT} fss_st_t;

   typedef struct packed {
      logic [15:0] ctl1;
      logic [15:0] ctl2;
      logic ovf;
      logic txf;
      logic rxf;
      logic evf;
      logic erf;
      logic xie;
      logic eie;
      logic [15:0] hold;
      logic [15:0] rbuf;
      logic [15:0] sr;
      fss_st_t st;
      logic [4:0] bitc;
      logic [4:0] syn_cnt;
      logic sync_act;
      logic [7:0] div;
      logic sck;
      logic sck_prev;
      logic sck_s1;
      logic sck_s2;
      logic syn_s1;
      logic syn_s2;
      logic sdi_s1;
      logic sdi_s2;
      logic sdo;
      logic sdo_oe;
      logic sck_oe;
      logic syn_o;
      logic syn_oe;
      logic [15:0] rdata;
      logic xirq;
      logic eirq;
   } fss_dev_t;

   typedef struct packed {
      fss_st_t st;
      logic [15:0] sr;
      logic [15:0] rx;
      logic [4:0] bitc;
      logic pend;
      logic [7:0] div;
      logic sck;
      logic sck_prev;
      logic sck_s1;
      logic sck_s2;
      logic syn_s1;
      logic syn_s2;
      logic sdi_s1;
      logic sdi_s2;
      logic sdo;
      logic syn_o;
      logic sck_oe;
      logic syn_oe;
      logic done;
      logic busy;
   } fss_peer_t;

   function automatic logic [4:0] fss_nbits(input logic w16);
      fss_nbits = w16 ? 5'h10 : 5'h08;
   endfunction

   function automatic logic fss_msb(input logic [15:0] v, input logic w16);
      fss_msb = w16 ? v[15] : v[7];
   endfunction
endpackage

// file: fss_if.sv
`timescale 1ns/1ps
interface fss_if;
   logic dev_sck_o;
   logic dev_sck_oe;
   logic dev_syn_o;
   logic dev_syn_oe;
   logic dev_sdo_o;
   logic dev_sdo_oe;
   logic peer_sck_o;
   logic peer_sck_oe;
   logic peer_syn_o;
   logic peer_syn_oe;
   logic peer_sdo_o;
   logic sck;
   logic syn;
   logic dev_data;
   logic peer_data;

   // undriven wires read low
   assign sck = dev_sck_oe ? dev_sck_o : (peer_sck_oe & peer_sck_o);
   assign syn = dev_syn_oe ? dev_syn_o : (peer_syn_oe & peer_syn_o);
   assign dev_data = dev_sdo_oe & dev_sdo_o;
   assign peer_data = peer_sdo_o;

   modport dev (output dev_sck_o, dev_sck_oe, dev_syn_o, dev_syn_oe, dev_sdo_o,
      dev_sdo_oe, input sck, syn, peer_data);
   modport peer (output peer_sck_o, peer_sck_oe, peer_syn_o, peer_syn_oe,
      peer_sdo_o, input sck, syn, dev_data);
endinterface

// file: fss_dev.sv
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "fss_regs.svh"
module fss_dev #(
   parameter int SCK_HALF = `FSS_SCK_HALF
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [4:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   output logic event_irq,
   output logic error_irq,
   fss_if.dev lnk
);
   fss_pkg::fss_dev_t s_q;
   fss_pkg::fss_dev_t s_d;

   logic frm;
   logic sfd;
   logic pol;
   logic dly;
   logic mst;
   logic clock_idle_polarity;
   logic odis;
   logic w16;
   logic sck_lvl;
   logic tx_e;
   logic smp_e;
   logic sync_in_act;
   logic [4:0] plen;
   logic end_p;

   //==============================================================
   // configuration decode
   assign frm = s_q.ctl2[`FSS_C2_FRM];
   assign sfd = s_q.ctl2[`FSS_C2_SFD];
   assign pol = s_q.ctl2[`FSS_C2_POL];
   assign dly = s_q.ctl2[`FSS_C2_DLY];
   assign mst = s_q.ctl1[`FSS_C1_MST];
   assign clock_idle_polarity = s_q.ctl1[`FSS_C1_CKP];
   assign odis = s_q.ctl1[`FSS_C1_ODIS];
   assign w16 = s_q.ctl1[`FSS_C1_W16];

   //==============================================================
   // clock edges
   // clock slave: edges found on the synchronised pin level
   assign sck_lvl = mst ? s_q.sck : s_q.sck_s2;
   assign tx_e = clock_idle_polarity ? (~sck_lvl & s_q.sck_prev) : (sck_lvl & ~s_q.sck_prev);
   assign smp_e = clock_idle_polarity ? (sck_lvl & ~s_q.sck_prev) : (~sck_lvl & s_q.sck_prev);
   assign sync_in_act = (s_q.syn_s2 == pol);
   // clock master holds the pulse a whole frame, clock slave one clock
   assign plen = mst ? fss_pkg::fss_nbits(w16) : 5'h01;
   assign end_p = s_q.sync_act && tx_e && (5'(s_q.syn_cnt + 5'h01) == plen);

   //==============================================================
   // next state
   always_comb begin
      logic done;
      done = 1'b0;
      s_d = s_q;
      s_d.sck_s1 = lnk.sck;
      s_d.sck_s2 = s_q.sck_s1;
      s_d.syn_s1 = lnk.syn;
      s_d.syn_s2 = s_q.syn_s1;
      s_d.sdi_s1 = lnk.peer_data;
      s_d.sdi_s2 = s_q.sdi_s1;
      s_d.sck_prev = sck_lvl;
      s_d.rdata = 16'h0000;

      // software clears come first so hardware sets below win
      if (wr) begin
         case (addr)
            `FSS_A_CTL1: s_d.ctl1 = wdata;
            `FSS_A_CTL2: s_d.ctl2 = wdata;
            `FSS_A_STAT: s_d.ovf = s_q.ovf & wdata[`FSS_ST_OVF];
            `FSS_A_IRQ: begin
               s_d.evf = s_q.evf & ~wdata[`FSS_IRQ_EVF];
               s_d.erf = s_q.erf & ~wdata[`FSS_IRQ_ERF];
               s_d.xie = wdata[`FSS_IRQ_XIE];
               s_d.eie = wdata[`FSS_IRQ_EIE];
            end
            default: ;
         endcase
      end
      if (rd) begin
         case (addr)
            `FSS_A_CTL1: s_d.rdata = s_q.ctl1;
            `FSS_A_CTL2: s_d.rdata = s_q.ctl2;
            `FSS_A_STAT: begin
               s_d.rdata[`FSS_ST_OVF] = s_q.ovf;
               s_d.rdata[`FSS_ST_TXF] = s_q.txf;
               s_d.rdata[`FSS_ST_RXF] = s_q.rxf;
            end
            `FSS_A_BUF: begin
               s_d.rdata = s_q.rbuf;
               s_d.rxf = 1'b0;
            end
            `FSS_A_IRQ: s_d.rdata[3:0] = {s_q.eie, s_q.xie, s_q.erf, s_q.evf};
            default: ;
         endcase
      end

      // free-running clock, not gated to the word in framed mode
      if (frm && mst) begin
         if (s_q.div == 8'(SCK_HALF - 1)) begin
            s_d.div = 8'h00;
            s_d.sck = ~s_q.sck;
         end else begin
            s_d.div = 8'(s_q.div + 8'h01);
         end
      end else begin
         s_d.div = 8'h00;
         s_d.sck = clock_idle_polarity;
      end

      if (s_q.sync_act && tx_e) begin
         s_d.syn_cnt = 5'(s_q.syn_cnt + 5'h01);
         if (end_p) begin
            s_d.sync_act = 1'b0;
         end
      end

      if (!frm) begin
         s_d.st = fss_pkg::ST_IDLE;
         s_d.sync_act = 1'b0;
      end else begin
         case (s_q.st)
            fss_pkg::ST_IDLE: begin
               if (!sfd) begin
                  if (tx_e && s_q.txf) begin
                     s_d.sync_act = 1'b1;
                     s_d.syn_cnt = 5'h00;
                     if (dly) begin
                        s_d.sr = s_q.hold;
                        s_d.sdo = fss_pkg::fss_msb(s_q.hold, w16);
                        s_d.txf = 1'b0;
                        s_d.bitc = 5'h00;
                        s_d.st = fss_pkg::ST_SHIFT;
                     end else begin
                        s_d.st = fss_pkg::ST_SYNC;
                     end
                  end
               end else if (smp_e && sync_in_act) begin
                  s_d.st = fss_pkg::ST_ARM;
               end
            end
            fss_pkg::ST_SYNC: begin
               if (end_p) begin
                  s_d.sr = s_q.hold;
                  s_d.sdo = fss_pkg::fss_msb(s_q.hold, w16);
                  s_d.txf = 1'b0;
                  s_d.bitc = 5'h00;
                  s_d.st = fss_pkg::ST_SHIFT;
               end
            end
            fss_pkg::ST_ARM: begin
               // stale holding word goes out when nothing new was written
               if (tx_e) begin
                  s_d.sr = s_q.hold;
                  s_d.sdo = fss_pkg::fss_msb(s_q.hold, w16);
                  s_d.txf = 1'b0;
                  s_d.bitc = 5'h00;
                  s_d.st = fss_pkg::ST_SHIFT;
               end
            end
            fss_pkg::ST_SHIFT: begin
               // sync samples are not looked at here
               if (tx_e) begin
                  s_d.sdo = fss_pkg::fss_msb(s_q.sr, w16);
               end
               if (smp_e) begin
                  s_d.sr = {s_q.sr[14:0], s_q.sdi_s2};
                  s_d.bitc = 5'(s_q.bitc + 5'h01);
                  if (5'(s_q.bitc + 5'h01) == fss_pkg::fss_nbits(w16)) begin
                     done = 1'b1;
                     s_d.st = fss_pkg::ST_IDLE;
                     if (s_q.rxf || s_q.ovf) begin
                        s_d.ovf = 1'b1;
                     end else begin
                        s_d.rbuf = w16 ? {s_q.sr[14:0], s_q.sdi_s2} :
                           {8'h00, s_q.sr[6:0], s_q.sdi_s2};
                        s_d.rxf = 1'b1;
                     end
                  end
               end
            end
            default: s_d.st = fss_pkg::ST_IDLE;
         endcase
      end

      // a write in the load cycle keeps the new word pending
      if (wr && addr == `FSS_A_BUF) begin
         s_d.hold = wdata;
         s_d.txf = 1'b1;
      end

      if ((s_d.rxf && !s_q.rxf) || (s_d.txf && !s_q.txf)) begin
         s_d.evf = 1'b1;
      end
      if (done && mst && sfd) begin
         s_d.evf = 1'b1;
      end
      if (s_d.ovf && !s_q.ovf) begin
         s_d.erf = 1'b1;
      end
      s_d.xirq = s_d.evf & s_d.xie;
      s_d.eirq = s_d.erf & s_d.eie;

      // when framed: clock pin as clock master, sync as frame master, data unless ODIS set
      s_d.sck_oe = frm & mst;
      s_d.syn_oe = frm & ~sfd;
      s_d.sdo_oe = frm & ~odis;
      s_d.syn_o = s_d.sync_act ? pol : ~pol;
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   //==============================================================
   // outputs
   assign rdata = s_q.rdata;
   assign event_irq = s_q.xirq;
   assign error_irq = s_q.eirq;
   assign lnk.dev_sck_o = s_q.sck;
   assign lnk.dev_sck_oe = s_q.sck_oe;
   assign lnk.dev_syn_o = s_q.syn_o;
   assign lnk.dev_syn_oe = s_q.syn_oe;
   assign lnk.dev_sdo_o = s_q.sdo;
   assign lnk.dev_sdo_oe = s_q.sdo_oe;
endmodule

// file: fss_peer.sv
`timescale 1ns/1ps
`include "fss_regs.svh"
module fss_peer #(
   parameter int SCK_HALF = `FSS_SCK_HALF
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic mk_clk,
   input wire logic mk_sync,
   input wire logic clock_idle_polarity,
   input wire logic pol,
   input wire logic w16,
   input wire logic [15:0] tx_word,
   input wire logic start,
   output logic [15:0] rx_word,
   output logic done,
   output logic busy,
   fss_if.peer lnk
);
   fss_pkg::fss_peer_t s_q;
   fss_pkg::fss_peer_t s_d;
   logic sck_lvl;
   logic tx_e;
   logic smp_e;

   assign sck_lvl = mk_clk ? s_q.sck : s_q.sck_s2;
   assign tx_e = clock_idle_polarity ? (~sck_lvl & s_q.sck_prev) : (sck_lvl & ~s_q.sck_prev);
   assign smp_e = clock_idle_polarity ? (sck_lvl & ~s_q.sck_prev) : (~sck_lvl & s_q.sck_prev);

   //==============================================================
   // next state
   always_comb begin
      s_d = s_q;
      s_d.sck_s1 = lnk.sck;
      s_d.sck_s2 = s_q.sck_s1;
      s_d.syn_s1 = lnk.syn;
      s_d.syn_s2 = s_q.syn_s1;
      s_d.sdi_s1 = lnk.dev_data;
      s_d.sdi_s2 = s_q.sdi_s1;
      s_d.sck_prev = sck_lvl;
      s_d.done = 1'b0;
      // clock never stops while this end supplies it
      if (mk_clk) begin
         if (s_q.div == 8'(SCK_HALF - 1)) begin
            s_d.div = 8'h00;
            s_d.sck = ~s_q.sck;
         end else begin
            s_d.div = 8'(s_q.div + 8'h01);
         end
      end else begin
         s_d.div = 8'h00;
         s_d.sck = clock_idle_polarity;
      end
      if (start && s_q.st == fss_pkg::ST_IDLE) begin
         s_d.pend = 1'b1;
         s_d.sr = tx_word;
      end
      case (s_q.st)
         fss_pkg::ST_IDLE: begin
            if (mk_sync) begin
               if (tx_e && s_q.pend) begin
                  s_d.syn_o = 1'b1;
                  s_d.st = fss_pkg::ST_ARM;
               end
            end else if (smp_e && s_q.pend && s_q.syn_s2 == pol) begin
               // an undriven sync wire must not start a frame with no word loaded
               s_d.bitc = 5'h00;
               s_d.st = fss_pkg::ST_ARM;
            end
         end
         fss_pkg::ST_ARM: begin
            // one clock of sync, data from the next transmit edge
            // a clock-master frame master holds sync a whole word, so wait it out
            if (tx_e) begin
               s_d.bitc = 5'(s_q.bitc + 5'h01);
               if (mk_sync || mk_clk || (5'(s_q.bitc + 5'h01) == fss_pkg::fss_nbits(w16))) begin
                  s_d.syn_o = 1'b0;
                  s_d.pend = 1'b0;
                  s_d.sdo = fss_pkg::fss_msb(s_q.sr, w16);
                  s_d.bitc = 5'h00;
                  s_d.busy = 1'b1;
                  s_d.st = fss_pkg::ST_SHIFT;
               end
            end
         end
         fss_pkg::ST_SHIFT: begin
            if (tx_e) begin
               s_d.sdo = fss_pkg::fss_msb(s_q.sr, w16);
            end
            if (smp_e) begin
               s_d.sr = {s_q.sr[14:0], s_q.sdi_s2};
               s_d.bitc = 5'(s_q.bitc + 5'h01);
               if (5'(s_q.bitc + 5'h01) == fss_pkg::fss_nbits(w16)) begin
                  s_d.rx = w16 ? {s_q.sr[14:0], s_q.sdi_s2} :
                     {8'h00, s_q.sr[6:0], s_q.sdi_s2};
                  s_d.done = 1'b1;
                  s_d.busy = 1'b0;
                  s_d.st = fss_pkg::ST_IDLE;
               end
            end
         end
         default: s_d.st = fss_pkg::ST_IDLE;
      endcase
      s_d.sck_oe = mk_clk;
      s_d.syn_oe = mk_sync;
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rx_word = s_q.rx;
   assign done = s_q.done;
   assign busy = s_q.busy;
   assign lnk.peer_sck_o = s_q.sck;
   assign lnk.peer_sck_oe = s_q.sck_oe;
   assign lnk.peer_syn_o = s_q.syn_o ? pol : ~pol;
   assign lnk.peer_syn_oe = s_q.syn_oe;
   assign lnk.peer_sdo_o = s_q.sdo;
endmodule

// file: fss_properties.sv
`timescale 1ns/1ps
module fss_properties #(
   parameter int SCK_HALF = 4
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic dev_sck_o,
   input wire logic dev_sck_oe,
   input wire logic dev_syn_o,
   input wire logic dev_syn_oe,
   input wire logic dev_sdo_o,
   input wire logic dev_sdo_oe,
   input wire logic peer_sck_o,
   input wire logic peer_sck_oe,
   input wire logic peer_syn_oe
);
   //==================================================================
   // link properties
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   // data may lag the clock toggle by one cycle of registering
   sequence s_mst_edge;
      $changed(dev_sck_o) || ($past(dev_sck_o, 1) != $past(dev_sck_o, 2));
   endsequence

   property p_sck_excl;
      !(dev_sck_oe && peer_sck_oe);
   endproperty
   a_sck_excl: assert property (p_sck_excl) else $error("two clock drivers");

   property p_syn_excl;
      !(dev_syn_oe && peer_syn_oe);
   endproperty
   a_syn_excl: assert property (p_syn_excl) else $error("two sync drivers");

   property p_dev_sck_free;
      (dev_sck_oe && $changed(dev_sck_o)) |-> ##[1:SCK_HALF] ($changed(dev_sck_o) || !dev_sck_oe);
   endproperty
   a_dev_sck_free: assert property (p_dev_sck_free) else $error("device clock stalled");

   property p_peer_sck_free;
      (peer_sck_oe && $changed(peer_sck_o)) |-> ##[1:SCK_HALF] ($changed(peer_sck_o) || !peer_sck_oe);
   endproperty
   a_peer_sck_free: assert property (p_peer_sck_free) else $error("peer clock stalled");

   property p_sdo_edge;
      (dev_sck_oe && dev_sdo_oe && $past(dev_sdo_oe) && $changed(dev_sdo_o)) |-> s_mst_edge;
   endproperty
   a_sdo_edge: assert property (p_sdo_edge) else $error("data changed off clock edge");

   property p_syn_edge;
      (dev_sck_oe && dev_syn_oe && $past(dev_syn_oe) && $changed(dev_syn_o)) |-> s_mst_edge;
   endproperty
   a_syn_edge: assert property (p_syn_edge) else $error("sync changed off clock edge");

   property p_clk_dedicated;
      dev_syn_oe |-> (dev_sck_oe || peer_sck_oe);
   endproperty
   a_clk_dedicated: assert property (p_clk_dedicated) else $error("sync without clock");

   property p_sdo_framed;
      dev_sdo_oe |-> (dev_syn_oe || peer_syn_oe);
   endproperty
   a_sdo_framed: assert property (p_sdo_framed) else $error("data out while unframed");

   c_dev_sync: cover property (dev_syn_oe && $changed(dev_syn_o));
   c_peer_sck: cover property (peer_sck_oe && $changed(peer_sck_o));
   c_dev_sdo: cover property (dev_sdo_oe && $changed(dev_sdo_o));
endmodule

// file: fss_test.sv
`timescale 1ns/1ps
`include "fss_regs.svh"
module fss_test;
   // two synchroniser stages each way need a half period well above four cycles
   localparam int HALF = 8;
   logic sys_clk, nrst, wr, rd, event_irq, error_irq;
   logic [4:0] addr;
   logic [15:0] wdata, rdata, tx_word, rx_word, v;
   logic mk_clk, mk_sync, clock_idle_polarity, pol, w16, start, done;
   int n_mismatch, checks;

   fss_if lnk();
   fss_dev #(.SCK_HALF(HALF)) i_fss_dev (.sys_clk(sys_clk), .nrst(nrst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .event_irq(event_irq),
      .error_irq(error_irq), .lnk(lnk.dev));
   fss_peer #(.SCK_HALF(HALF)) i_fss_peer (.sys_clk(sys_clk), .nrst(nrst), .mk_clk(mk_clk),
      .mk_sync(mk_sync), .clock_idle_polarity(clock_idle_polarity), .pol(pol), .w16(w16), .tx_word(tx_word), .start(start),
      .rx_word(rx_word), .done(done), .busy(), .lnk(lnk.peer));
   fss_properties #(.SCK_HALF(HALF)) u_chk (.sys_clk(sys_clk), .nrst(nrst),
      .dev_sck_o(lnk.dev_sck_o), .dev_sck_oe(lnk.dev_sck_oe), .dev_syn_o(lnk.dev_syn_o),
      .dev_syn_oe(lnk.dev_syn_oe), .dev_sdo_o(lnk.dev_sdo_o), .dev_sdo_oe(lnk.dev_sdo_oe),
      .peer_sck_o(lnk.peer_sck_o), .peer_sck_oe(lnk.peer_sck_oe),
      .peer_syn_oe(lnk.peer_syn_oe));

   //==================================================================
   // clock and helpers
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic finish_test();
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus_wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      @(negedge sys_clk);
      d = rdata;
   endtask

   task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
      logic [15:0] d;
      bus_rd(a, d);
      chk(d, exp);
   endtask

   task automatic timeout(input logic cond);
      if (!cond) begin
         n_mismatch++;
         $display("[FAIL] %0t wait ran out", $time);
         finish_test();
      end
   endtask

   // poll a status bit; a hang ends the run
   task automatic poll(input int b);
      logic [15:0] d;
      int n;
      d = 16'h0000;
      for (n = 0; n < 60 && d[b] !== 1'b1; n++) begin
         bus_rd(`FSS_A_STAT, d);
      end
      timeout(d[b] === 1'b1);
   endtask

   task automatic peer_go(input logic [15:0] w);
      @(posedge sys_clk);
      tx_word <= w;
      start <= 1'b1;
      @(posedge sys_clk);
      start <= 1'b0;
   endtask

   task automatic wait_done();
      int n;
      for (n = 0; n < 4000 && done !== 1'b1; n++) begin
         @(negedge sys_clk);
      end
      timeout(done === 1'b1);
   endtask

   // framing off first so the two ends never fight over a pin
   task automatic cfg(input logic [15:0] c1, input logic [15:0] c2, input logic [4:0] p);
      bus_wr(`FSS_A_CTL2, 16'h0000);
      repeat (4) @(posedge sys_clk);
      {mk_clk, mk_sync, clock_idle_polarity, pol, w16} <= p;
      repeat (4) @(posedge sys_clk);
      bus_wr(`FSS_A_CTL1, c1);
      bus_wr(`FSS_A_CTL2, c2);
      repeat (40) @(posedge sys_clk);
   endtask

   //==================================================================
   // main sequence
   initial begin
      n_mismatch = 0;
      checks = 0;
      nrst = 1'b0;
      {wr, rd, start, addr, wdata, tx_word} = '0;
      {mk_clk, mk_sync, clock_idle_polarity, pol, w16} = 5'h00;
      repeat (12) @(posedge sys_clk);
      nrst <= 1'b1;
      rd_chk(`FSS_A_CTL1, 16'h0000);
      rd_chk(`FSS_A_CTL2, 16'h0000);
      rd_chk(`FSS_A_STAT, 16'h0000);
      rd_chk(`FSS_A_IRQ, 16'h0000);
      bus_wr(5'h14, 16'hFFFF);
      rd_chk(5'h14, 16'h0000);
      chk({15'h0000, lnk.dev_sck_oe}, 16'h0000);
      $display("test reset done");

      cfg(16'h0020, 16'hA000, 5'h02);
      chk({15'h0000, lnk.syn}, 16'h0000);
      peer_go(16'h00A6);
      bus_wr(`FSS_A_BUF, 16'h0035);
      wait_done();
      chk(rx_word, 16'h0035);
      poll(`FSS_ST_RXF);
      rd_chk(`FSS_A_STAT, 16'h0001);
      rd_chk(`FSS_A_IRQ, 16'h0001);
      rd_chk(`FSS_A_BUF, 16'h00A6);
      rd_chk(`FSS_A_STAT, 16'h0000);
      $display("test clock and frame master done");

      bus_wr(`FSS_A_IRQ, 16'h000F);
      rd_chk(`FSS_A_IRQ, 16'h000C);
      peer_go(16'h0011);
      bus_wr(`FSS_A_BUF, 16'h0022);
      wait_done();
      poll(`FSS_ST_RXF);
      chk({15'h0000, event_irq}, 16'h0001);
      peer_go(16'h0044);
      bus_wr(`FSS_A_BUF, 16'h0055);
      wait_done();
      poll(`FSS_ST_OVF);
      repeat (2) @(negedge sys_clk);
      chk({15'h0000, error_irq}, 16'h0001);
      rd_chk(`FSS_A_STAT, 16'h0041);
      rd_chk(`FSS_A_BUF, 16'h0011);
      peer_go(16'h0066);
      bus_wr(`FSS_A_BUF, 16'h0077);
      wait_done();
      chk(rx_word, 16'h0077);
      repeat (40) @(posedge sys_clk);
      rd_chk(`FSS_A_STAT, 16'h0040);
      bus_wr(`FSS_A_STAT, 16'h0000);
      bus_wr(`FSS_A_IRQ, 16'h000F);
      repeat (2) @(negedge sys_clk);
      chk({14'h0000, error_irq, event_irq}, 16'h0000);
      rd_chk(`FSS_A_STAT, 16'h0000);
      rd_chk(`FSS_A_IRQ, 16'h000C);
      $display("test overrun done");

      cfg(16'h0440, 16'h8000, 5'h15);
      chk({15'h0000, lnk.syn}, 16'h0001);
      peer_go(16'h1234);
      bus_wr(`FSS_A_BUF, 16'hBEEF);
      wait_done();
      chk(rx_word, 16'hBEEF);
      poll(`FSS_ST_RXF);
      rd_chk(`FSS_A_BUF, 16'h1234);
      $display("test clock slave frame master done");

      cfg(16'h0020, 16'hE000, 5'h0A);
      bus_wr(`FSS_A_IRQ, 16'h000F);
      peer_go(16'h0099);
      wait_done();
      chk(rx_word, 16'h00EF);
      poll(`FSS_ST_RXF);
      rd_chk(`FSS_A_BUF, 16'h0099);
      rd_chk(`FSS_A_IRQ, 16'h000D);
      $display("test frame slave done");

      bus_wr(`FSS_A_CTL1, 16'h0820);
      repeat (4) @(posedge sys_clk);
      chk({15'h0000, lnk.dev_sdo_oe}, 16'h0000);
      peer_go(16'h0042);
      wait_done();
      chk(rx_word, 16'h0000);
      poll(`FSS_ST_RXF);
      rd_chk(`FSS_A_BUF, 16'h0042);
      $display("test receive only done");
      finish_test();
   end
endmodule
